/* core/sir_pkg.sv */
// Constants and types shared by the socket interrupt and retry registers
package sir_pkg;

    // Geometry
    localparam int NSOCK = 8;
    localparam int AW    = 16;
    localparam int DW    = 8;

    // Register byte addresses
    localparam logic [15:0] OFS_IRQ_ENABLE   = 16'h0016;
    localparam logic [15:0] OFS_RETRY_IVL_HI = 16'h0017;
    localparam logic [15:0] OFS_RETRY_IVL_LO = 16'h0018;
    localparam logic [15:0] OFS_RETRY_LIMIT  = 16'h0019;
    localparam logic [15:0] OFS_AUTH_TYPE_HI = 16'h001C;
    localparam logic [15:0] OFS_AUTH_TYPE_LO = 16'h001D;
    localparam logic [15:0] OFS_AUTH_ALGO    = 16'h001E;
    localparam logic [15:0] OFS_CHIP_REV     = 16'h001F;
    localparam logic [15:0] OFS_ECHO_PERIOD  = 16'h0028;
    localparam logic [15:0] OFS_MAGIC        = 16'h0029;
    localparam logic [15:0] OFS_HOLDOFF_HI   = 16'h0030;
    localparam logic [15:0] OFS_HOLDOFF_LO   = 16'h0031;
    localparam logic [15:0] OFS_IRQ_SUMMARY  = 16'h0034;

    // Reset values
    localparam logic [7:0]  RST_IRQ_ENABLE  = 8'h00;
    localparam logic [15:0] RST_RETRY_IVL   = 16'h07D0;
    localparam logic [7:0]  RST_RETRY_LIMIT = 8'h08;
    localparam logic [15:0] RST_AUTH_TYPE   = 16'h0000;
    localparam logic [7:0]  RST_AUTH_ALGO   = 8'h00;
    localparam logic [7:0]  RST_ECHO_PERIOD = 8'h00;
    localparam logic [7:0]  RST_MAGIC       = 8'h00;
    localparam logic [15:0] RST_HOLDOFF     = 16'h0000;
    localparam logic [7:0]  RST_IRQ_SUMMARY = 8'h00;
    localparam logic [7:0]  READ_ZERO       = 8'h00;

    // Revision code; value is arbitrary
    localparam logic [7:0]  CHIP_REV_CODE   = 8'h5A;

    // Authentication type codes
    localparam logic [15:0] AUTH_PAP  = 16'hC023;
    localparam logic [15:0] AUTH_CHAP = 16'hC223;

    // Interval doubling ceiling
    localparam logic [16:0] IVL_CEIL = 17'h0_FFFF;

    // Timing: clock rate, retry unit, echo unit
    localparam int CLK_MHZ      = 125;
    localparam int RETRY_UNIT_US = 100;
    localparam int ECHO_UNIT_MS  = 25;
    localparam int RETRY_UNIT_CYC = RETRY_UNIT_US * CLK_MHZ;
    localparam int ECHO_UNIT_CYC  = ECHO_UNIT_MS * 1000 * CLK_MHZ;

    // Interrupt output sequencer
    typedef enum logic [1:0] {
        IRQ_IDLE = 2'b00,
        IRQ_LOW  = 2'b01,
        IRQ_HOLD = 2'b10
    } sir_irq_state_t;

    // Per-socket retry timer
    typedef enum logic {
        RT_IDLE = 1'b0,
        RT_WAIT = 1'b1
    } sir_rt_state_t;

endpackage

/* core/sir_regs.sv */
// Socket interrupt summary, mask, hold-off, retry timers and PPP registers
//
// Function
// RULE1: Enabled summary bit raises interrupt.
// RULE2: Disabled summary bit raises none.
// RULE3: Retry interval: 16 bits, 100 us units, reset 2000.
// RULE4: Retry interval high byte at lower address.
// RULE5: Retransmit on late or missing reply.
// RULE6: Retry limit resets to 8; limit+1 waits then timeout.
// RULE7: TCP timeout also closes socket.
// RULE8: ARP request resent per expired wait.
// RULE9: ARP timeout after limit+1 waits.
// RULE10: TCP wait doubles, held past 65535.
// RULE11: Read-only auth type, PAP or CHAP.
// RULE12: Read-only auth algorithm byte.
// RULE13: Read-only fixed revision byte.
// RULE14: Echo period paces LCP echo, 25 ms per count.
// RULE15: Writable LCP magic byte.
// RULE16: Hold-off sets wait before reassert.
// RULE17: Released line reasserts after hold-off plus one.
// RULE18: Socket interrupt sets summary bit.
// RULE19: Cleared socket flags clear summary bit.
// RULE20: Line low while enabled bits pend; code releases it for hold-off plus one when an enabled socket is cleared.
// RULE21: Host reads summary, clears socket flags.
`timescale 1ns/1ps
`default_nettype none

module sir_regs
    import sir_pkg::*;
#(
    parameter int RETRY_TICK_CYC = sir_pkg::RETRY_UNIT_CYC,
    parameter int ECHO_TICK_CYC  = sir_pkg::ECHO_UNIT_CYC
)
(
    input  wire logic                      mclk,
    input  wire logic                      resetn,
    // Byte register port from host port logic
    input  wire logic [sir_pkg::AW-1:0]    regAddr,
    input  wire logic [sir_pkg::DW-1:0]    regWrData,
    input  wire logic                      regWrEn,
    input  wire logic                      regRdEn,
    output logic      [sir_pkg::DW-1:0]    regRdData,
    output logic                           regRdValid,
    // Socket event side
    input  wire logic [sir_pkg::NSOCK-1:0] sockIrqEvent,
    input  wire logic [sir_pkg::NSOCK-1:0] sockFlagsClear,
    input  wire logic [sir_pkg::NSOCK-1:0] sockWaitStart,
    input  wire logic [sir_pkg::NSOCK-1:0] sockWaitIsTcp,
    input  wire logic [sir_pkg::NSOCK-1:0] sockAckRcvd,
    output logic      [sir_pkg::NSOCK-1:0] sockRetransmit,
    output logic      [sir_pkg::NSOCK-1:0] sockTimeout,
    output logic      [sir_pkg::NSOCK-1:0] sockStateClosed,
    // PPP link side
    input  wire logic                      authUpdate,
    input  wire logic [15:0]               authTypeIn,
    input  wire logic [7:0]                authAlgoIn,
    output logic      [7:0]                linkMagicValue,
    output logic                           lcpEchoReq,
    // Active-low interrupt line
    output logic                           irqOut_n
);
    import sir_pkg::*;

    localparam logic [31:0] RETRY_LAST = 32'(RETRY_TICK_CYC - 1);
    localparam logic [31:0] ECHO_LAST  = 32'(ECHO_TICK_CYC - 1);

    // Double the wait while it fits
    function automatic logic [15:0] nextInterval(input logic [15:0] cur);
        logic [16:0] dbl;
        dbl = {cur, 1'b0};
        if (dbl > IVL_CEIL)
            nextInterval = cur;
        else
            nextInterval = dbl[15:0];
    endfunction

    // Register write strobe for one address
    function automatic logic wrHit(input logic [15:0] a, input logic [15:0] o,
                                   input logic we);
        wrHit = we && (a == o);
    endfunction

    logic [7:0]     irqEnable_q;
    logic [15:0]    retryIvl_q;
    logic [7:0]     retryLimit_q;
    logic [15:0]    authType_q;
    logic [7:0]     authAlgo_q;
    logic [7:0]     echoPeriod_q;
    logic [7:0]     magic_q;
    logic [15:0]    holdoff_q;
    logic [7:0]     summary_q;
    logic [7:0]     rdData_q;
    logic           rdValid_q;

    logic [31:0]    retryPre_q;
    logic           retryTick_q;
    logic [31:0]    echoPre_q;
    logic [7:0]     echoCnt_q;
    logic           echoReq_q;

    sir_rt_state_t  rtState_q [NSOCK];
    logic [15:0]    rtIvl_q   [NSOCK];
    logic [15:0]    rtTicks_q [NSOCK];
    logic [7:0]     rtCount_q [NSOCK];
    logic [7:0]     rtIsTcp_q;
    logic [7:0]     retx_q;
    logic [7:0]     tmo_q;
    logic [7:0]     closed_q;

    sir_irq_state_t irqState_q;
    sir_irq_state_t irqState_d;
    logic [15:0]    irqWait_q;
    logic           relHit_q;
    logic           irqOut_n_q;
    logic           pending;

    // Writable configuration registers
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            irqEnable_q  <= RST_IRQ_ENABLE;
            retryIvl_q   <= RST_RETRY_IVL;
            retryLimit_q <= RST_RETRY_LIMIT;
            echoPeriod_q <= RST_ECHO_PERIOD;
            magic_q      <= RST_MAGIC;
            holdoff_q    <= RST_HOLDOFF;
        end
        else
        begin
            if (wrHit(regAddr, OFS_IRQ_ENABLE, regWrEn))
                irqEnable_q <= regWrData;
            // RULE4: upper byte first
            if (wrHit(regAddr, OFS_RETRY_IVL_HI, regWrEn))
                retryIvl_q[15:8] <= regWrData;
            if (wrHit(regAddr, OFS_RETRY_IVL_LO, regWrEn))
                retryIvl_q[7:0] <= regWrData;
            // RULE6: retry limit store
            if (wrHit(regAddr, OFS_RETRY_LIMIT, regWrEn))
                retryLimit_q <= regWrData;
            // RULE14: echo period store
            if (wrHit(regAddr, OFS_ECHO_PERIOD, regWrEn))
                echoPeriod_q <= regWrData;
            // RULE15: magic byte store
            if (wrHit(regAddr, OFS_MAGIC, regWrEn))
                magic_q <= regWrData;
            // RULE16: hold-off store
            if (wrHit(regAddr, OFS_HOLDOFF_HI, regWrEn))
                holdoff_q[15:8] <= regWrData;
            if (wrHit(regAddr, OFS_HOLDOFF_LO, regWrEn))
                holdoff_q[7:0] <= regWrData;
        end
    end

    // Authentication status captured from the PPP engine
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            authType_q <= RST_AUTH_TYPE;
            authAlgo_q <= RST_AUTH_ALGO;
        end
        // RULE11: auth type capture
        else if (authUpdate)
        begin
            authType_q <= authTypeIn;
            // RULE12: algorithm capture
            authAlgo_q <= authAlgoIn;
        end
    end

    // Read port, one cycle latency, unmapped reads return zero
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdData_q  <= READ_ZERO;
            rdValid_q <= 1'b0;
        end
        else
        begin
            rdValid_q <= regRdEn;
            if (regRdEn)
            begin
                unique case (regAddr)
                    OFS_IRQ_ENABLE:   rdData_q <= irqEnable_q;
                    OFS_RETRY_IVL_HI: rdData_q <= retryIvl_q[15:8];
                    OFS_RETRY_IVL_LO: rdData_q <= retryIvl_q[7:0];
                    OFS_RETRY_LIMIT:  rdData_q <= retryLimit_q;
                    OFS_AUTH_TYPE_HI: rdData_q <= authType_q[15:8];
                    OFS_AUTH_TYPE_LO: rdData_q <= authType_q[7:0];
                    OFS_AUTH_ALGO:    rdData_q <= authAlgo_q;
                    // RULE13: fixed revision
                    OFS_CHIP_REV:     rdData_q <= CHIP_REV_CODE;
                    OFS_ECHO_PERIOD:  rdData_q <= echoPeriod_q;
                    OFS_MAGIC:        rdData_q <= magic_q;
                    OFS_HOLDOFF_HI:   rdData_q <= holdoff_q[15:8];
                    OFS_HOLDOFF_LO:   rdData_q <= holdoff_q[7:0];
                    OFS_IRQ_SUMMARY:  rdData_q <= summary_q;
                    default:          rdData_q <= READ_ZERO;
                endcase
            end
        end
    end

    // Socket summary bits; a new event wins over a clear
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            summary_q <= RST_IRQ_SUMMARY;
        else
            // RULE18: set on event; RULE19: clear when flags zeroed
            summary_q <= (summary_q & ~sockFlagsClear) | sockIrqEvent | tmo_q;
    end

    // Shared 100 us retry tick
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            retryPre_q  <= 32'h0000_0000;
            retryTick_q <= 1'b0;
        end
        else if (retryPre_q == RETRY_LAST)
        begin
            retryPre_q  <= 32'h0000_0000;
            retryTick_q <= 1'b1;
        end
        else
        begin
            retryPre_q  <= retryPre_q + 32'h0000_0001;
            retryTick_q <= 1'b0;
        end
    end

    // Per-socket retransmission timers
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < NSOCK; i++)
            begin
                rtState_q[i] <= RT_IDLE;
                rtIvl_q[i]   <= RST_RETRY_IVL;
                rtTicks_q[i] <= RST_RETRY_IVL;
                rtCount_q[i] <= 8'h00;
            end
            rtIsTcp_q <= 8'h00;
            retx_q    <= 8'h00;
            tmo_q     <= 8'h00;
            closed_q  <= 8'h00;
        end
        else
        begin
            retx_q   <= 8'h00;
            tmo_q    <= 8'h00;
            closed_q <= 8'h00;
            for (int i = 0; i < NSOCK; i++)
            begin
                // RULE3: wait loaded from the interval register
                if (sockWaitStart[i])
                begin
                    rtState_q[i] <= RT_WAIT;
                    rtIvl_q[i]   <= retryIvl_q;
                    rtTicks_q[i] <= retryIvl_q;
                    rtCount_q[i] <= 8'h00;
                    rtIsTcp_q[i] <= sockWaitIsTcp[i];
                end
                else if (rtState_q[i] == RT_WAIT)
                begin
                    if (sockAckRcvd[i])
                        rtState_q[i] <= RT_IDLE;
                    else if (retryTick_q && rtTicks_q[i] <= 16'h0001)
                    begin
                        // RULE6: limit plus one waits end in timeout
                        if (rtCount_q[i] == retryLimit_q)
                        begin
                            rtState_q[i] <= RT_IDLE;
                            // RULE9: final timeout flag
                            tmo_q[i]    <= 1'b1;
                            // RULE7: TCP also closes the socket
                            closed_q[i] <= rtIsTcp_q[i];
                        end
                        else
                        begin
                            // RULE5: retransmit on expiry; RULE8: ARP resend
                            retx_q[i]    <= 1'b1;
                            rtCount_q[i] <= rtCount_q[i] + 8'h01;
                            // RULE10: TCP doubles, held at current value when the double exceeds the ceiling
                            if (rtIsTcp_q[i])
                            begin
                                rtIvl_q[i]   <= nextInterval(rtIvl_q[i]);
                                rtTicks_q[i] <= nextInterval(rtIvl_q[i]);
                            end
                            else
                                rtTicks_q[i] <= rtIvl_q[i];
                        end
                    end
                    else if (retryTick_q)
                        rtTicks_q[i] <= rtTicks_q[i] - 16'h0001;
                end
            end
        end
    end

    // LCP echo pacing, 25 ms units, zero period disables it
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            echoPre_q <= 32'h0000_0000;
            echoCnt_q <= 8'h00;
            echoReq_q <= 1'b0;
        end
        else
        begin
            echoReq_q <= 1'b0;
            if (echoPeriod_q == 8'h00)
            begin
                echoPre_q <= 32'h0000_0000;
                echoCnt_q <= 8'h00;
            end
            else if (echoPre_q == ECHO_LAST)
            begin
                echoPre_q <= 32'h0000_0000;
                // RULE14: one request per period
                if (echoCnt_q + 8'h01 >= echoPeriod_q)
                begin
                    echoCnt_q <= 8'h00;
                    echoReq_q <= 1'b1;
                end
                else
                    echoCnt_q <= echoCnt_q + 8'h01;
            end
            else
                echoPre_q <= echoPre_q + 32'h0000_0001;
        end
    end

    // RULE1: enabled summary bits; RULE2: disabled bits masked
    assign pending = |(summary_q & irqEnable_q);

    // Interrupt sequencer next state
    always_comb
    begin
        irqState_d = irqState_q;
        unique case (irqState_q)
            IRQ_IDLE:
                if (pending)
                    irqState_d = IRQ_LOW;
            // RULE20: held low while enabled bits pend, until an enabled socket is cleared
            IRQ_LOW:
                if (!pending || relHit_q)
                    irqState_d = IRQ_HOLD;
            // RULE17: reassert after hold-off expiry
            IRQ_HOLD:
                if (irqWait_q == 16'h0000)
                    irqState_d = pending ? IRQ_LOW : IRQ_IDLE;
            default:
                irqState_d = IRQ_IDLE;
        endcase
    end

    // Interrupt sequencer state, hold-off count and output line
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            irqState_q <= IRQ_IDLE;
            irqWait_q  <= RST_HOLDOFF;
            irqOut_n_q <= 1'b1;
            relHit_q   <= 1'b0;
        end
        else
        begin
            irqState_q <= irqState_d;
            // RULE20: an enabled socket cleared releases the line
            relHit_q   <= |(sockFlagsClear & summary_q & irqEnable_q
                            & ~sockIrqEvent & ~tmo_q);
            irqOut_n_q <= (irqState_d != IRQ_LOW);
            // RULE16: hold-off count of setting plus one clocks
            if (irqState_q == IRQ_LOW)
                irqWait_q <= holdoff_q;
            else if (irqState_q == IRQ_HOLD && irqWait_q != 16'h0000)
                irqWait_q <= irqWait_q - 16'h0001;
        end
    end

    // Outputs straight from flops
    assign regRdData       = rdData_q;
    assign regRdValid      = rdValid_q;
    assign sockRetransmit  = retx_q;
    assign sockTimeout     = tmo_q;
    assign sockStateClosed = closed_q;
    assign linkMagicValue  = magic_q;
    assign lcpEchoReq      = echoReq_q;
    assign irqOut_n        = irqOut_n_q;

endmodule // sir_regs

`default_nettype wire

/* tb/sir_regs_chk.sv */
// Port-level checker for the socket interrupt and retry registers
`timescale 1ns/1ps
`default_nettype none
module sir_regs_chk
    import sir_pkg::*;
(
    input wire logic                      mclk,
    input wire logic                      resetn,
    input wire logic [sir_pkg::AW-1:0]    regAddr,
    input wire logic [sir_pkg::DW-1:0]    regWrData,
    input wire logic                      regWrEn,
    input wire logic                      regRdEn,
    input wire logic [sir_pkg::DW-1:0]    regRdData,
    input wire logic                      regRdValid,
    input wire logic [sir_pkg::NSOCK-1:0] sockIrqEvent,
    input wire logic [sir_pkg::NSOCK-1:0] sockFlagsClear,
    input wire logic [sir_pkg::NSOCK-1:0] sockWaitStart,
    input wire logic [sir_pkg::NSOCK-1:0] sockAckRcvd,
    input wire logic [sir_pkg::NSOCK-1:0] sockRetransmit,
    input wire logic [sir_pkg::NSOCK-1:0] sockTimeout,
    input wire logic [sir_pkg::NSOCK-1:0] sockStateClosed,
    input wire logic [7:0]                linkMagicValue,
    input wire logic                      irqOut_n
);
    logic [7:0]  en_q;
    logic [7:0]  sum_q;
    logic [7:0]  mag_q;
    logic [15:0] hold_q;
    logic [16:0] hiCnt_q;
    logic        pend;

    // Enabled pending summary bits
    assign pend = |(sum_q & en_q);

    // Shadow of writable registers
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            en_q   <= 8'h00;
            mag_q  <= 8'h00;
            hold_q <= 16'h0000;
        end
        else if (regWrEn)
        begin
            case (regAddr)
                OFS_IRQ_ENABLE: en_q <= regWrData;
                OFS_MAGIC:      mag_q <= regWrData;
                OFS_HOLDOFF_HI: hold_q[15:8] <= regWrData;
                OFS_HOLDOFF_LO: hold_q[7:0] <= regWrData;
                default:        ;
            endcase
        end
    end

    // Shadow summary; a new event wins over a clear
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            sum_q <= 8'h00;
        else
            sum_q <= (sum_q & ~sockFlagsClear) | sockIrqEvent | sockTimeout;
    end

    // Cycles the line stays high while something enabled is pending
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            hiCnt_q <= 17'h0_0000;
        else
            hiCnt_q <= (pend && irqOut_n) ? hiCnt_q + 17'h0_0001 : 17'h0_0000;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_magSettled;
        $stable(mag_q) [*2];
    endsequence

    sequence s_irqSteady;
        !irqOut_n && pend && $stable(sum_q) && $stable(en_q);
    endsequence

    AST_IRQ_MASKED: assert property (
        !pend |=> irqOut_n) else $error("line low unmasked");
    AST_IRQ_HOLD: assert property (
        s_irqSteady |=> !irqOut_n) else $error("line released early");
    AST_HOLDOFF: assert property (
        hiCnt_q <= {1'b0, hold_q} + 17'h0_0002)
        else $error("late assert");
    AST_REV_READ: assert property (
        regRdEn && regAddr == OFS_CHIP_REV |=> regRdValid
        && regRdData == CHIP_REV_CODE) else $error("revision read wrong");
    AST_MAGIC_OUT: assert property (
        s_magSettled |-> linkMagicValue == mag_q)
        else $error("magic differs");
    AST_CLOSED_TO: assert property (
        |sockStateClosed |-> (sockStateClosed & ~sockTimeout) == 8'h00)
        else $error("closed without timeout");
    AST_TO_PULSE: assert property (
        (sockTimeout & $past(sockTimeout)) == 8'h00)
        else $error("timeout pulse too long");
    AST_ACK_STOP: assert property (
        sockAckRcvd[0] && !sockWaitStart[0] |=> ##1
        (!sockRetransmit[0] && !sockTimeout[0]) [*8])
        else $error("timer ran after reply");
endmodule // sir_regs_chk

bind sir_regs sir_regs_chk chk (.*);
`default_nettype wire

/* tb/sir_host_model.sv */
// Host model that services the interrupt line by clearing socket flags
`timescale 1ns/1ps
`default_nettype none
module sir_host_model
    import sir_pkg::*;
(
    input  wire logic                      mclk,
    input  wire logic                      resetn,
    input  wire logic                      irqOut_n,
    input  wire logic                      svcEn,
    input  wire logic [sir_pkg::NSOCK-1:0] svcMask,
    output logic      [sir_pkg::NSOCK-1:0] sockFlagsClear
);
    logic [1:0] dly_q;
    logic       armed_q;

    // clear the svcMask flags, once per low episode
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            dly_q          <= 2'h0;
            armed_q        <= 1'b1;
            sockFlagsClear <= 8'h00;
        end
        else
        begin
            sockFlagsClear <= 8'h00;
            if (irqOut_n || !svcEn)
            begin
                armed_q <= 1'b1;
                dly_q   <= 2'h0;
            end
            else if (armed_q)
            begin
                dly_q <= dly_q + 2'h1;
                if (dly_q == 2'h3)
                begin
                    sockFlagsClear <= svcMask;
                    armed_q        <= 1'b0;
                end
            end
        end
    end
endmodule // sir_host_model
`default_nettype wire

/* tb/sir_regs_tb.sv */
// Testbench for the socket interrupt and retry registers
`timescale 1ns/1ps
`default_nettype none
module sir_regs_tb;
    import sir_pkg::*;
    logic        mclk = 0, resetn = 0, regWrEn = 0, regRdEn = 0;
    logic        authUpdate = 0, svcEn = 0, regRdValid, lcpEchoReq, irqOut_n;
    logic [15:0] regAddr = 0, authTypeIn = 0;
    logic [7:0]  regWrData = 0, authAlgoIn = 0, svcMask = 0, sockAckRcvd = 0;
    logic [7:0]  sockIrqEvent = 0, sockWaitStart = 0, sockWaitIsTcp = 0;
    logic [7:0]  regRdData, sockFlagsClear, sockRetransmit, sockTimeout;
    logic [7:0]  sockStateClosed, linkMagicValue;
    int          err_count = 0, cmp_count = 0, cyc = 0, n, t, g;
    logic [15:0] ra[14] = '{16'h0016, 16'h0017, 16'h0018, 16'h0019, 16'h001C,
        16'h001D, 16'h001E, 16'h001F, 16'h0028, 16'h0029, 16'h0030,
        16'h0031, 16'h0034, 16'h0020};
    logic [7:0]  rv[14] = '{8'h00, 8'h07, 8'hD0, 8'h08, 8'h00, 8'h00, 8'h00,
        CHIP_REV_CODE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [15:0] atab[2] = '{AUTH_PAP, AUTH_CHAP};
    logic [7:0]  htab[2] = '{8'h00, 8'h0F};

    always #4 mclk = ~mclk;

    sir_regs #(.RETRY_TICK_CYC(1), .ECHO_TICK_CYC(4)) uut (.*);

    sir_host_model host (.*);

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWrEn <= 1;
        regAddr <= a;
        regWrData <= d;
        @(posedge mclk);
        regWrEn <= 0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk);
        regRdEn <= 1;
        regAddr <= a;
        @(posedge mclk);
        regRdEn <= 0;
        #1;
        chk(regRdValid, 1);
        chk(regRdData, e);
    endtask

    task automatic wirq(input logic v);
        repeat (40)
        begin
            @(negedge mclk);
            if (irqOut_n === v)
                break;
        end
        chk(irqOut_n, v);
    endtask

    task automatic retry(input int s, input logic tcp, input int ivl, lim);
        wr(OFS_RETRY_IVL_HI, ivl[15:8]);
        wr(OFS_RETRY_IVL_LO, ivl[7:0]);
        wr(OFS_RETRY_LIMIT, lim[7:0]);
        @(posedge mclk);
        sockWaitStart <= 8'h01 << s;
        sockWaitIsTcp <= tcp ? 8'hFF : 8'h00;
        @(posedge mclk);
        sockWaitStart <= 0;
        g = ivl;
        n = 0;
        t = 0;
        repeat (70000)
        begin
            @(negedge mclk);
            t++;
            if (sockTimeout[s] === 1'b1)
            begin
                chk(n, lim);
                chk(sockStateClosed[s], tcp);
                if (n > 0)
                    chk(t, g);
                n = 99;
                break;
            end
            if (sockRetransmit[s] === 1'b1)
            begin
                if (n > 0)
                    chk(t, g);
                if (tcp && g * 2 <= 65535)
                    g = g * 2;
                n++;
                t = 0;
            end
        end
        chk(n, 99);
    endtask

    // Cycle ceiling against hangs
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            err_count++;
            final_report;
        end
    end

    initial
    begin
        repeat (6) @(posedge mclk);
        resetn <= 1;
        foreach (ra[i])
            rd(ra[i], rv[i]);
        wr(OFS_RETRY_IVL_HI, 8'h0F);
        wr(OFS_RETRY_IVL_LO, 8'hA0);
        rd(OFS_RETRY_IVL_HI, 8'h0F);
        rd(OFS_RETRY_IVL_LO, 8'hA0);
        // Read-only places ignore writes
        wr(OFS_AUTH_TYPE_HI, 8'hFF);
        wr(OFS_CHIP_REV, 8'hFF);
        wr(OFS_IRQ_SUMMARY, 8'hFF);
        rd(OFS_AUTH_TYPE_HI, 8'h00);
        rd(OFS_CHIP_REV, CHIP_REV_CODE);
        rd(OFS_IRQ_SUMMARY, 8'h00);
        wr(OFS_MAGIC, 8'hC5);
        rd(OFS_MAGIC, 8'hC5);
        chk(linkMagicValue, 8'hC5);
        // Negotiated authentication codes
        foreach (atab[i])
        begin
            @(posedge mclk);
            authUpdate <= 1;
            authTypeIn <= atab[i];
            authAlgoIn <= atab[i][11:4];
            @(posedge mclk);
            authUpdate <= 0;
            rd(OFS_AUTH_TYPE_HI, atab[i][15:8]);
            rd(OFS_AUTH_TYPE_LO, atab[i][7:0]);
            rd(OFS_AUTH_ALGO, atab[i][11:4]);
        end
        // Echo requests every three periods of four cycles
        wr(OFS_ECHO_PERIOD, 8'h03);
        n = 0;
        t = 0;
        repeat (60)
        begin
            @(negedge mclk);
            t++;
            if (lcpEchoReq === 1'b1)
            begin
                if (n > 0)
                    chk(t, 12);
                n++;
                t = 0;
            end
        end
        chk(n > 2, 1);
        // Masked event stays silent until enabled
        @(posedge mclk) sockIrqEvent <= 8'h08;
        @(posedge mclk) sockIrqEvent <= 0;
        repeat (8) @(posedge mclk);
        chk(irqOut_n, 1);
        rd(OFS_IRQ_SUMMARY, 8'h08);
        svcMask <= 8'h08;
        svcEn <= 1;
        wr(OFS_IRQ_ENABLE, 8'h08);
        wirq(0);
        wirq(1);
        rd(OFS_IRQ_SUMMARY, 8'h00);
        // Reassert after release with another socket pending
        foreach (htab[i])
        begin
            svcEn <= 0;
            wr(OFS_HOLDOFF_HI, 8'h00);
            wr(OFS_HOLDOFF_LO, htab[i]);
            wr(OFS_IRQ_ENABLE, 8'h03);
            @(posedge mclk) sockIrqEvent <= 8'h03;
            @(posedge mclk) sockIrqEvent <= 0;
            wirq(0);
            svcMask <= 8'h01;
            svcEn <= 1;
            wirq(1);
            n = 0;
            while (irqOut_n === 1'b1 && n < 100)
            begin
                @(negedge mclk);
                n++;
            end
            chk(n, htab[i] + 1);
            svcEn <= 0;
            @(posedge mclk);
            svcMask <= 8'h02;
            svcEn <= 1;
            wirq(1);
        end
        retry(2, 0, 5, 2);
        retry(1, 1, 3, 3);
        // Reply before expiry stops the timer
        @(posedge mclk) sockWaitStart <= 8'h01;
        @(posedge mclk) sockWaitStart <= 0;
        sockAckRcvd <= 8'h01;
        @(posedge mclk) sockAckRcvd <= 0;
        n = 0;
        repeat (30) @(posedge mclk) n += sockRetransmit[0] | sockTimeout[0];
        chk(n, 0);
        retry(6, 1, 32768, 1);
        final_report;
    end
endmodule // sir_regs_tb
`default_nettype wire
